// File: rtl/fdfl_pkg.sv
// Shared constants, storage kinds and depth arithmetic for the single-clock FIFO.
// Assumes every user of the FIFO shares one clock with it.
package fdfl_pkg;

  typedef enum logic [3:0] {
    FDFL_BLOCK_RAM = 4'h1,
    FDFL_DIST_RAM  = 4'h2,
    FDFL_SHIFT_RAM = 4'h4,
    FDFL_HARD_PRIM = 4'h8
  } fdfl_store_t;

  localparam int FDFL_HARD_MIN_DEPTH = 512;
  localparam int FDFL_PRELOAD_EXTRA = 2;
  localparam int FDFL_INDEP_LOSS = 1;
  localparam int FDFL_PROG_LATENCY = 1;
  localparam int FDFL_BOTH_REGS = 2;

  localparam logic FDFL_FULL_RST = 1'b0;
  localparam logic FDFL_AFULL_RST = 1'b0;
  localparam logic FDFL_EMPTY_RST = 1'b1;
  localparam logic FDFL_AEMPTY_RST = 1'b1;
  localparam logic FDFL_PFULL_RST = 1'b0;
  localparam logic FDFL_PEMPTY_RST = 1'b1;
  localparam logic FDFL_VALID_RST = 1'b0;
  localparam logic FDFL_ACK_RST = 1'b0;
  localparam logic FDFL_REJ_RST = 1'b0;

  function automatic int fdfl_cascade(input int wr_depth, input int prim_depth);
    int d;
    d = (wr_depth < FDFL_HARD_MIN_DEPTH) ? FDFL_HARD_MIN_DEPTH : wr_depth;
    return (d + prim_depth - 1) / prim_depth;
  endfunction

  function automatic int fdfl_wr_depth(input fdfl_store_t st, input bit indep, input bit preload,
                                       input int out_regs, input int wd, input int rd, input int pd);
    int n;
    int d;
    n = fdfl_cascade(wd, pd);
    if (st == FDFL_HARD_PRIM) begin
      d = preload ? (pd + 1) * n : ((pd + 1) * n) - 1;
    end else if (!indep) begin
      d = preload ? wd + FDFL_PRELOAD_EXTRA : wd;
    end else begin
      d = preload ? (wd - FDFL_INDEP_LOSS) + 2 * (wd / rd) : wd - FDFL_INDEP_LOSS;
    end
    if (preload && out_regs == FDFL_BOTH_REGS && st != FDFL_HARD_PRIM) begin
      d = d + 1;
    end
    return d;
  endfunction

  function automatic int fdfl_rd_depth(input fdfl_store_t st, input bit indep, input bit preload,
                                       input int out_regs, input int wd, input int rd, input int pd);
    int d;
    if (st == FDFL_HARD_PRIM) begin
      d = fdfl_wr_depth(st, indep, preload, out_regs, wd, rd, pd);
    end else if (!indep) begin
      d = preload ? rd + FDFL_PRELOAD_EXTRA : rd;
    end else begin
      d = preload ? rd + 1 : rd - FDFL_INDEP_LOSS;
    end
    if (preload && out_regs == FDFL_BOTH_REGS && st != FDFL_HARD_PRIM) begin
      d = d + 1;
    end
    return d;
  endfunction

endpackage

// File: rtl/fdfl_mem.sv
// Simple dual-port storage array with a registered read port and write-through bypass.
// Assumes one clock; the bypass lets a preload head see a word written the same edge.
`timescale 1ns/1ps
module fdfl_mem
  import fdfl_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] rdata_r;

  // Array has no reset so it can map onto RAM
  always_ff @(posedge clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (clr) begin
      rdata_r <= '0;
    end else if (re) begin
      rdata_r <= (we && waddr == raddr) ? wdata : mem_r[raddr];
    end
  end

  assign rdata = rdata_r;

endmodule

// File: rtl/fdfl_prog.sv
// Programmable threshold flags for the FIFO occupancy.
// Assumes the occupancy and its next value come from the same clock domain.
`timescale 1ns/1ps
module fdfl_prog
  import fdfl_pkg::*;
#(
  parameter int CW = 5,
  parameter int PF_THRESH = 12,
  parameter int PE_THRESH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  // Occupancy
  input wire logic wr_ok,
  input wire logic [CW-1:0] count_cur,
  input wire logic [CW-1:0] count_nxt,
  // Flags
  output logic prog_full,
  output logic prog_empty
);

  logic prog_full_r;
  logic prog_empty_r;

  // Registered from the settled count, one edge behind any operation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_full_r <= FDFL_PFULL_RST;
    end else if (clr) begin
      prog_full_r <= FDFL_PFULL_RST;
    end else begin
      prog_full_r <= (count_cur >= CW'(PF_THRESH));
    end
  end

  // A write moves it at once, a lone read one edge later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_empty_r <= FDFL_PEMPTY_RST;
    end else if (clr) begin
      prog_empty_r <= FDFL_PEMPTY_RST;
    end else begin
      prog_empty_r <= ((wr_ok ? count_nxt : count_cur) <= CW'(PE_THRESH));
    end
  end

  assign prog_full = prog_full_r;
  assign prog_empty = prog_empty_r;

endmodule

// File: rtl/fdfl_fifo.sv
// Single-clock FIFO with standard or first-word preload read, flags and handshakes.
// Assumes writer and reader share clk; srst is a synchronous clear from the same domain.
//
// Overview of operation
// - Common clock standard read: usable depths equal configured depths exactly.
// - Common clock preload read: usable depths are configured depths plus two.
// - Independent clock standard read: usable depths are configured depths minus one.
// - Independent preload: read depth plus one; write depth minus one plus twice ratio.
// - Unequal write and read depths allowed only with block RAM storage.
// - Both output registers in preload mode add one more usable entry.
// - Hard primitive storage has minimum depth 512, effective depth per mode.
// - Cascaded primitive count is write depth over primitive depth, rounded up.
// - Latency zero means the flag changes on the operation's own clock edge.
// - Write updates full, almost full, ack, overflow at once; prog full one later.
// - Read updates empty, almost empty, valid, underflow, count at once; prog empty later.
// - Read updates full and almost full at once; prog full one edge later.
// - Write ack and overflow respond only to write requests.
// - Write updates empty, almost empty, prog empty and count at once.
// - Underflow, and valid in standard read, respond only to read requests; preload valid follows a present head word.
// - Write request while full raises overflow.
// - Read request while empty raises underflow.
// - One-cycle synchronous reset suffices; transactions accepted the next cycle.
`timescale 1ns/1ps
module fdfl_fifo
  import fdfl_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int WR_DEPTH = 16,
  parameter int RD_DEPTH = 16,
  parameter fdfl_store_t STORE = FDFL_BLOCK_RAM,
  parameter bit INDEP_CLK = 1'b0,
  parameter bit PRELOAD = 1'b0,
  parameter int OUT_REGS = 0,
  parameter int PRIM_DEPTH = 512,
  parameter int PF_THRESH = 12,
  parameter int PE_THRESH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic srst,
  // Write side
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] din,
  output logic full,
  output logic almost_full,
  output logic prog_full,
  output logic wr_ack,
  output logic overflow,
  // Read side
  input wire logic rd_en,
  output logic [WIDTH-1:0] dout,
  output logic empty,
  output logic almost_empty,
  output logic prog_empty,
  output logic valid,
  output logic underflow,
  output logic [$clog2(fdfl_wr_depth(STORE, INDEP_CLK, PRELOAD, OUT_REGS, WR_DEPTH, RD_DEPTH,
                                     PRIM_DEPTH) + 1)-1:0] data_count
);

  // Depth follows clocking, read mode, storage and output registers
  localparam int DEPTH = fdfl_wr_depth(STORE, INDEP_CLK, PRELOAD, OUT_REGS, WR_DEPTH, RD_DEPTH,
                                       PRIM_DEPTH);
  localparam int RD_USABLE = fdfl_rd_depth(STORE, INDEP_CLK, PRELOAD, OUT_REGS, WR_DEPTH, RD_DEPTH,
                                           PRIM_DEPTH);
  localparam int CASCADE = fdfl_cascade(WR_DEPTH, PRIM_DEPTH);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic wr_ok;
  logic rd_ok;
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW-1:0] wr_ptr_inc;
  logic [AW-1:0] rd_ptr_inc;
  logic [AW-1:0] rd_addr;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic full_r;
  logic almost_full_r;
  logic empty_r;
  logic almost_empty_r;
  logic wr_ack_r;
  logic overflow_r;
  logic valid_r;
  logic underflow_r;

  // Requests against the wrong flag are refused, never stored or read
  assign wr_ok = wr_en && !full_r;
  assign rd_ok = rd_en && !empty_r;
  assign wr_ptr_inc = (wr_ptr_r == LAST_C) ? '0 : wr_ptr_r + 1'b1;
  assign rd_ptr_inc = (rd_ptr_r == LAST_C) ? '0 : rd_ptr_r + 1'b1;

  always_comb begin
    count_nxt = count_r;
    if (wr_ok && !rd_ok) begin
      count_nxt = count_r + 1'b1;
    end else if (rd_ok && !wr_ok) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Preload keeps the head word fetched; standard fetches only on a read
  assign rd_addr = (PRELOAD && rd_ok) ? rd_ptr_inc : rd_ptr_r;

  fdfl_mem #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk(clk),
    .rst(rst),
    .clr(srst),
    .we(wr_ok),
    .waddr(wr_ptr_r),
    .wdata(din),
    .re(PRELOAD ? 1'b1 : rd_ok),
    .raddr(rd_addr),
    .rdata(dout)
  );

  fdfl_prog #(
    .CW(CW),
    .PF_THRESH(PF_THRESH),
    .PE_THRESH(PE_THRESH)
  ) u_prog (
    .clk(clk),
    .rst(rst),
    .clr(srst),
    .wr_ok(wr_ok),
    .count_cur(count_r),
    .count_nxt(count_nxt),
    .prog_full(prog_full),
    .prog_empty(prog_empty)
  );

  // Pointers; a single srst cycle clears everything
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (wr_ok) begin
        wr_ptr_r <= wr_ptr_inc;
      end
      if (rd_ok) begin
        rd_ptr_r <= rd_ptr_inc;
      end
    end
  end

  // Occupancy and level flags move on the operation's own edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
      full_r <= FDFL_FULL_RST;
      almost_full_r <= FDFL_AFULL_RST;
      empty_r <= FDFL_EMPTY_RST;
      almost_empty_r <= FDFL_AEMPTY_RST;
    end else if (srst) begin
      count_r <= '0;
      full_r <= FDFL_FULL_RST;
      almost_full_r <= FDFL_AFULL_RST;
      empty_r <= FDFL_EMPTY_RST;
      almost_empty_r <= FDFL_AEMPTY_RST;
    end else begin
      count_r <= count_nxt;
      full_r <= (count_nxt == DEPTH_C);
      almost_full_r <= (count_nxt == DEPTH_C - 1'b1);
      empty_r <= (count_nxt == '0);
      almost_empty_r <= (count_nxt <= CW'(1));
    end
  end

  // Write handshakes look at wr_en only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ack_r <= FDFL_ACK_RST;
      overflow_r <= FDFL_REJ_RST;
    end else if (srst) begin
      wr_ack_r <= FDFL_ACK_RST;
      overflow_r <= FDFL_REJ_RST;
    end else begin
      wr_ack_r <= wr_ok;
      overflow_r <= wr_en && full_r;
    end
  end

  // Read handshakes look at rd_en only; preload valid tracks a present head word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_r <= FDFL_VALID_RST;
      underflow_r <= FDFL_REJ_RST;
    end else if (srst) begin
      valid_r <= FDFL_VALID_RST;
      underflow_r <= FDFL_REJ_RST;
    end else begin
      valid_r <= PRELOAD ? (count_nxt != '0) : rd_ok;
      underflow_r <= rd_en && empty_r;
    end
  end

  assign full = full_r;
  assign almost_full = almost_full_r;
  assign wr_ack = wr_ack_r;
  assign overflow = overflow_r;
  assign empty = empty_r;
  assign almost_empty = almost_empty_r;
  assign valid = valid_r;
  assign underflow = underflow_r;
  assign data_count = count_r;

  // Checks
  logic [CW-1:0] past_count_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      past_count_r <= '0;
    end else begin
      past_count_r <= count_r;
    end
  end

  depth_ratio_a: assert property (@(posedge clk) disable iff (rst)
    (WR_DEPTH == RD_DEPTH) || (STORE == FDFL_BLOCK_RAM))
    else $error("unequal port depths need block RAM storage");

  hard_depth_a: assert property (@(posedge clk) disable iff (rst)
    (STORE != FDFL_HARD_PRIM) || (CASCADE * PRIM_DEPTH >= FDFL_HARD_MIN_DEPTH))
    else $error("hard primitive cascade below minimum depth");

  usable_depth_a: assert property (@(posedge clk) disable iff (rst)
    (STORE == FDFL_HARD_PRIM) || INDEP_CLK ||
    (DEPTH == WR_DEPTH + (PRELOAD ? FDFL_PRELOAD_EXTRA + ((OUT_REGS == FDFL_BOTH_REGS) ? 1 : 0) : 0)))
    else $error("usable depth differs from configured depth");

  full_level_a: assert property (@(posedge clk) disable iff (rst)
    full == (data_count == DEPTH_C))
    else $error("full disagrees with occupancy");

  empty_level_a: assert property (@(posedge clk) disable iff (rst)
    empty == (data_count == '0))
    else $error("empty disagrees with occupancy");

  write_ack_a: assert property (@(posedge clk) disable iff (rst || srst)
    wr_en && !full |=> wr_ack && data_count != '0)
    else $error("accepted write not acknowledged");

  overflow_flag_a: assert property (@(posedge clk) disable iff (rst || srst)
    wr_en && full && !rd_en |=> overflow && full && $stable(data_count))
    else $error("write while full not rejected");

  underflow_flag_a: assert property (@(posedge clk) disable iff (rst || srst)
    rd_en && empty && !wr_en |=> underflow && !wr_ack && empty)
    else $error("read while empty not rejected");

  read_count_a: assert property (@(posedge clk) disable iff (rst || srst)
    rd_en && !empty && !wr_en |=> data_count == $past(data_count) - 1'b1)
    else $error("read did not lower occupancy on its edge");

  prog_full_lag_a: assert property (@(posedge clk) disable iff (rst || srst)
    ##1 !$past(srst) |-> prog_full == (past_count_r >= CW'(PF_THRESH)))
    else $error("prog full not one edge behind occupancy");

  sync_reset_a: assert property (@(posedge clk) disable iff (rst)
    srst |=> empty && !full && data_count == '0 && !valid && !wr_ack)
    else $error("one srst cycle did not clear the FIFO");

  almost_full_a: assert property (@(posedge clk) disable iff (rst)
    almost_full == (data_count == DEPTH_C - 1'b1))
    else $error("almost full disagrees with occupancy");

  almost_empty_a: assert property (@(posedge clk) disable iff (rst)
    almost_empty == (data_count <= CW'(1)))
    else $error("almost empty disagrees with occupancy");

  write_only_a: assert property (@(posedge clk) disable iff (rst || srst)
    !wr_en |=> !wr_ack && !overflow)
    else $error("write handshake moved without a write");

  read_only_a: assert property (@(posedge clk) disable iff (rst || srst)
    !rd_en |=> !underflow && (PRELOAD || !valid))
    else $error("read handshake moved without a read");

  write_count_a: assert property (@(posedge clk) disable iff (rst || srst)
    wr_en && !full && !rd_en |=> data_count == $past(data_count) + 1'b1)
    else $error("write did not raise occupancy on its edge");

  prog_empty_a: assert property (@(posedge clk) disable iff (rst || srst)
    wr_en && !full |=> prog_empty == (data_count <= CW'(PE_THRESH)))
    else $error("prog empty lagged a write");

  read_valid_a: assert property (@(posedge clk) disable iff (rst || srst)
    rd_en && !empty && !PRELOAD |=> valid)
    else $error("accepted read gave no valid");

  // Read side must gain exactly what the write side gains on one clock
  read_depth_a: assert property (@(posedge clk) disable iff (rst)
    (STORE == FDFL_HARD_PRIM) || INDEP_CLK || (RD_USABLE - RD_DEPTH == DEPTH - WR_DEPTH))
    else $error("usable read depth differs from write side");

  fill_cov: cover property (@(posedge clk) disable iff (rst) full ##[1:1000] empty);
  reject_cov: cover property (@(posedge clk) disable iff (rst) overflow ##[1:200] underflow);
  both_cov: cover property (@(posedge clk) disable iff (rst) wr_en && rd_en && !empty && !full);
  almost_cov: cover property (@(posedge clk) disable iff (rst) almost_full ##[1:100] almost_empty);
  srst_cov: cover property (@(posedge clk) disable iff (rst) !empty ##1 srst);

endmodule

// File: sim/fdfl_partner.sv
// Writer and reader logic on the fabric side of the FIFO.
// Assumes the bench sets the commands at rising edges; full and empty come straight from flops.
`timescale 1ns/1ps
module fdfl_partner
  import fdfl_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic srst,
  // Commands from the bench
  input wire logic wr_cmd,
  input wire logic rd_cmd,
  input wire logic bad,
  // FIFO status
  input wire logic full,
  input wire logic empty,
  // FIFO requests
  output logic wr_en,
  output logic [WIDTH-1:0] din,
  output logic rd_en
);
  logic [WIDTH-1:0] wseq_r;

  // Requests are held back while full or empty unless a refusal is wanted
  assign wr_en = wr_cmd & (~full | bad);
  assign rd_en = rd_cmd & (~empty | bad);
  // Inverted word when idle, so a stale capture shows up as a data error
  assign din = wr_en ? wseq_r : ~wseq_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wseq_r <= '0;
    end else if (wr_en && !full && !srst) begin
      wseq_r <= wseq_r + WIDTH'(1);
    end
  end
endmodule

// File: sim/fdfl_fifo_tb.sv
// Self-checking bench for the single-clock FIFO in standard and preload read modes.
// Assumes default storage and one clock; each cyc call sets requests for the following edge.
`timescale 1ns/1ps
module fdfl_fifo_tb
  import fdfl_pkg::*;
;
  localparam int DEPTH = 16;
  localparam int PF = 12;
  localparam int PE = 2;
  localparam int CW = $clog2(DEPTH + 1);

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic srst = 1'b0;
  logic wr_cmd = 1'b0;
  logic rd_cmd = 1'b0;
  logic bad = 1'b0;
  logic wr_en;
  logic rd_en;
  logic [7:0] din;
  logic [7:0] dout;
  logic full, almost_full, prog_full, wr_ack, overflow;
  logic empty, almost_empty, prog_empty, valid, underflow;
  logic [CW-1:0] data_count;
  logic [9:0] flg;
  logic p_wr_cmd = 1'b0;
  logic p_rd_cmd = 1'b0;
  logic p_wr_en;
  logic p_rd_en;
  logic [7:0] p_din;
  logic [7:0] p_dout;
  logic p_full, p_empty, p_valid;
  logic [$clog2(DEPTH + 3)-1:0] p_count;
  int n_mismatch = 0;
  int n_tests = 0;

  assign flg = {full, almost_full, prog_full, wr_ack, overflow, empty, almost_empty, prog_empty, valid, underflow};

  always #20 clk = ~clk;

  fdfl_partner #(.WIDTH(8)) far_u (.clk(clk), .rst(rst), .srst(srst), .wr_cmd(wr_cmd), .rd_cmd(rd_cmd),
    .bad(bad), .full(full), .empty(empty), .wr_en(wr_en), .din(din), .rd_en(rd_en));

  fdfl_fifo #(.WIDTH(8), .WR_DEPTH(DEPTH), .RD_DEPTH(DEPTH), .PF_THRESH(PF), .PE_THRESH(PE)) dut_u (
    .clk(clk), .rst(rst), .srst(srst), .wr_en(wr_en), .din(din), .full(full), .almost_full(almost_full),
    .prog_full(prog_full), .wr_ack(wr_ack), .overflow(overflow), .rd_en(rd_en), .dout(dout), .empty(empty),
    .almost_empty(almost_empty), .prog_empty(prog_empty), .valid(valid), .underflow(underflow),
    .data_count(data_count));

  // Second FIFO in preload mode, fed by a writer and reader of its own
  fdfl_partner #(.WIDTH(8)) far2_u (.clk(clk), .rst(rst), .srst(srst), .wr_cmd(p_wr_cmd), .rd_cmd(p_rd_cmd),
    .bad(1'b0), .full(p_full), .empty(p_empty), .wr_en(p_wr_en), .din(p_din), .rd_en(p_rd_en));

  fdfl_fifo #(.WIDTH(8), .WR_DEPTH(DEPTH), .RD_DEPTH(DEPTH), .PRELOAD(1'b1), .PF_THRESH(PF),
    .PE_THRESH(PE)) pre_u (
    .clk(clk), .rst(rst), .srst(srst), .wr_en(p_wr_en), .din(p_din), .full(p_full), .almost_full(),
    .prog_full(), .wr_ack(), .overflow(), .rd_en(p_rd_en), .dout(p_dout), .empty(p_empty), .almost_empty(),
    .prog_empty(), .valid(p_valid), .underflow(), .data_count(p_count));

  task automatic wrap_up();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Edge where the previous requests are taken; new requests land for the next edge
  task automatic cyc(input logic w, input logic r, input logic b, input logic s);
    @(posedge clk);
    wr_cmd <= w;
    rd_cmd <= r;
    bad <= b;
    srst <= s;
    #1;
  endtask

  task automatic t_fill();
    int i;
    logic [9:0] e;
    cyc(1'b1, 1'b0, 1'b0, 1'b0);
    for (i = 1; i <= DEPTH; i++) begin
      cyc(i < DEPTH, 1'b0, 1'b0, 1'b0);
      e = {i == DEPTH, i == DEPTH - 1, i - 1 >= PF, 3'b100, i <= 1, i <= PE, 2'b00};
      chk("fill flags", e, flg);
      chk("fill count", i, data_count);
    end
    cyc(1'b1, 1'b0, 1'b1, 1'b0);
    cyc(1'b0, 1'b0, 1'b0, 1'b0);
    chk("overflow flags", 10'h2A0, flg);
    chk("overflow count", DEPTH, data_count);
    cyc(1'b0, 1'b0, 1'b0, 1'b0);
    chk("overflow clear", 10'h280, flg);
  endtask

  task automatic t_drain();
    int i;
    int n;
    logic [9:0] e;
    cyc(1'b0, 1'b1, 1'b0, 1'b0);
    for (i = 1; i <= DEPTH; i++) begin
      cyc(1'b0, i < DEPTH, 1'b0, 1'b0);
      n = DEPTH - i;
      e = {1'b0, n == DEPTH - 1, n + 1 >= PF, 2'b00, n == 0, n <= 1, n + 1 <= PE, 2'b10};
      chk("drain flags", e, flg);
      chk("drain count", n, data_count);
      chk("drain data", i - 1, dout);
    end
    cyc(1'b0, 1'b1, 1'b1, 1'b0);
    cyc(1'b0, 1'b0, 1'b0, 1'b0);
    chk("underflow flags", 10'h01D, flg);
    chk("underflow count", 0, data_count);
  endtask

  task automatic t_simul();
    cyc(1'b1, 1'b0, 1'b0, 1'b0);
    cyc(1'b1, 1'b1, 1'b0, 1'b0);
    chk("lone write", 10'h04C, flg);
    cyc(1'b0, 1'b0, 1'b0, 1'b0);
    chk("write read flags", 10'h04E, flg);
    chk("write read count", 1, data_count);
    chk("write read data", 8'h10, dout);
    cyc(1'b0, 1'b0, 1'b0, 1'b0);
    chk("idle flags", 10'h00C, flg);
  endtask

  task automatic t_srst();
    cyc(1'b0, 1'b0, 1'b0, 1'b1);
    cyc(1'b1, 1'b0, 1'b0, 1'b0);
    chk("clear flags", 10'h01C, flg);
    chk("clear count", 0, data_count);
    cyc(1'b0, 1'b1, 1'b0, 1'b0);
    chk("after clear ack", 10'h04C, flg);
    cyc(1'b0, 1'b0, 1'b0, 1'b0);
    chk("after clear data", 8'h12, dout);
    chk("after clear count", 0, data_count);
  endtask

  // Preload: the head word shows without a read, and two entries more than configured fit
  task automatic t_preload();
    int i;
    @(posedge clk);
    p_wr_cmd <= 1'b1;
    for (i = 1; i <= DEPTH + 2; i++) begin
      @(posedge clk);
      p_wr_cmd <= (i < DEPTH + 2);
      #1;
      chk("preload full", i == DEPTH + 2, p_full);
      chk("preload count", i, p_count);
      chk("preload head", {1'b1, 8'h00}, {p_valid, p_dout});
    end
    @(posedge clk);
    p_rd_cmd <= 1'b1;
    for (i = 1; i <= DEPTH + 2; i++) begin
      @(posedge clk);
      p_rd_cmd <= (i < DEPTH + 2);
      #1;
      chk("preload left", DEPTH + 2 - i, p_count);
      chk("preload valid", i < DEPTH + 2, p_valid);
      if (i < DEPTH + 2) begin
        chk("preload next", i, p_dout);
      end
    end
  endtask

  // Whole run is about 100 cycles; this only trips on a hang
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset flags", 10'h01C, flg);
    chk("reset count", 0, data_count);
    t_fill();
    t_drain();
    t_simul();
    t_srst();
    t_preload();
    wrap_up();
  end
endmodule
